// ### core/battery_charge_phase_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "charge_phase_consts.svh"
module battery_charge_phase_control (
  // clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_b,
  // ahb-lite slave
  input  wire logic                     i_hsel,
  input  wire logic [7:0]               i_haddr,
  input  wire logic [1:0]               i_htrans,
  input  wire logic                     i_hwrite,
  input  wire logic [2:0]               i_hsize,
  input  wire logic [31:0]              i_hwdata,
  input  wire logic                     i_hready,
  output logic      [31:0]              o_hrdata,
  output logic                          o_hreadyout,
  output logic                          o_hresp,
  // nonvolatile defaults
  input  wire logic [1:0]               i_otp_short_threshold,
  input  wire logic [1:0]               i_otp_precharge_current_sel,
  input  wire logic [5:0]               i_otp_min_system_high_level,
  // analog comparators (asynchronous)
  input  wire logic                     i_cmp_above_short,
  input  wire logic                     i_cmp_above_full,
  input  wire logic                     i_cmp_above_batmin,
  input  wire logic                     i_cmp_eoc_current,
  input  wire logic                     i_cmp_cv_regime,
  input  wire logic                     i_cmp_recharge_drop,
  input  wire logic                     i_cmp_source_regulated,
  input  wire logic                     i_cmp_sys_sag,
  input  wire logic                     i_cmp_charge_current_zero,
  // analog loop controls
  output logic      [2:0]               o_phase,
  output logic                          o_charge_enable,
  output logic                          o_system_reg_enable,
  output logic                          o_short_current_sel,
  output logic                          o_precond_reduce,
  output logic      [1:0]               o_precharge_current_sel,
  output logic      [1:0]               o_short_threshold_sel,
  output logic                          o_tracking_supply,
  output logic      [5:0]               o_battery_min_high_level,
  output logic      [1:0]               o_dropout_half_sel,
  output logic                          o_sys_anticollapse_active,
  output logic                          o_anticollapse_low_fixed,
  output logic      [2:0]               o_end_of_charge_current_level,
  output logic      [2:0]               o_input_collapse_level,
  output logic      [5:0]               o_input_current_sel,
  output logic      [5:0]               o_charge_voltage_sel,
  output logic      [3:0]               o_charge_current_sel,
  output logic                          o_supplement_mode,
  output logic                          o_eoc_irq
);
  import charge_phase_pkg::*;

  localparam int NCMP = 9;

  typedef struct packed {
    // two-stage comparator synchroniser
    logic [NCMP-1:0] sync1;
    logic [NCMP-1:0] sync2;
    phase_t          phase;
    logic            enable;
    logic            single_charge_bit;
    logic            gate_on_finish;
    logic            power_path;
    logic [2:0]      eoc_level;
    logic            eoc_flag;
    logic            loaded;
    logic [5:0]      battery_min_high_reg;
    logic [1:0]      dropout_setting;
    logic [2:0]      input_collapse_level;
    logic [5:0]      input_current_sel;
    logic [5:0]      charge_voltage_sel;
    logic [3:0]      charge_current_sel;
    logic            dp_valid;
    logic            dp_write;
    logic [7:0]      dp_addr;
    logic [31:0]     rdata;
    logic            charge_en;
    logic            sysreg_en;
    logic            short_cur;
    logic            pre_reduce;
    logic            tracking;
    logic            sys_ac;
    logic            ac_low;
    logic            supplement;
    logic            irq;
    // bus handshake and static nonvolatile selects, kept in flops
    logic            ready;
    logic [1:0]      otp_short;
    logic [1:0]      otp_pre;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [NCMP-1:0] cmp_raw;
  logic            above_short;
  logic            above_full;
  logic            above_batmin;
  logic            eoc_current;
  logic            cv_regime;
  logic            recharge_drop;
  logic            src_reg;
  logic            sys_sag;
  logic            cur_zero;
  logic            eoc_hit;
  logic            wr_eoc_clr;
  logic [5:0]      batmin_default;

  assign cmp_raw = {i_cmp_charge_current_zero, i_cmp_sys_sag, i_cmp_source_regulated,
                    i_cmp_recharge_drop, i_cmp_cv_regime, i_cmp_eoc_current,
                    i_cmp_above_batmin, i_cmp_above_full, i_cmp_above_short};
  // only the second stage is read
  assign {cur_zero, sys_sag, src_reg, recharge_drop, cv_regime, eoc_current,
          above_batmin, above_full, above_short} = st_r.sync2;

  // clamp to 3.7 V
  assign batmin_default = (i_otp_min_system_high_level > `BATMIN_CLAMP) ?
                          `BATMIN_CLAMP : i_otp_min_system_high_level;

  // end-of-charge counts only in constant voltage full charge
  assign eoc_hit = (st_r.phase == PH_FULL) && cv_regime && eoc_current;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = cmp_raw;
    st_nxt.sync2 = st_r.sync1;
    wr_eoc_clr   = 1'b0;

    // ahb-lite address phase capture
    if (i_hready) begin
      st_nxt.dp_valid = i_hsel && i_htrans[1];
      st_nxt.dp_write = i_hwrite;
      st_nxt.dp_addr  = i_haddr;
    end

    // write data phase
    if (st_r.dp_valid && st_r.dp_write) begin
      case (st_r.dp_addr)
        `REG_CTRL_OFS: begin
          st_nxt.enable            = i_hwdata[`CTRL_ENABLE_BIT];
          st_nxt.single_charge_bit = i_hwdata[`CTRL_SINGLE_BIT];
          st_nxt.gate_on_finish    = i_hwdata[`CTRL_GATEFIN_BIT];
          st_nxt.power_path        = i_hwdata[`CTRL_PPATH_BIT];
          st_nxt.eoc_level         = i_hwdata[`CTRL_EOCLVL_LSB +: 3];
          wr_eoc_clr               = i_hwdata[`CTRL_EOC_CLR_BIT];
        end
        `REG_BATMIN_OFS: begin
          st_nxt.battery_min_high_reg = i_hwdata[5:0];
        end
        `REG_COMP_OFS: begin
          st_nxt.dropout_setting = i_hwdata[1:0];
        end
        `REG_COLLAPSE_OFS: begin
          st_nxt.input_collapse_level = i_hwdata[2:0];
        end
        `REG_LIMIT_OFS: begin
          st_nxt.input_current_sel  = i_hwdata[5:0];
          st_nxt.charge_voltage_sel = i_hwdata[11:6];
          st_nxt.charge_current_sel = i_hwdata[15:12];
        end
        default: begin
        end
      endcase
    end

    // one-time load of the nonvolatile default after reset
    if (!st_r.loaded) begin
      st_nxt.loaded               = 1'b1;
      st_nxt.battery_min_high_reg = batmin_default;
    end

    // phase sequencing, one step per clock from synchronised levels
    case (st_r.phase)
      PH_PRECOND: begin
        // a shorted cell never leaves this phase
        if (above_short) begin
          st_nxt.phase = PH_PRECHG;
        end
      end
      PH_PRECHG: begin
        if (!above_short) begin
          st_nxt.phase = PH_PRECOND;
        end else if (above_full && src_reg) begin
          st_nxt.phase = PH_FULL;
        end
      end
      PH_FULL: begin
        if (eoc_hit) begin
          if (st_r.power_path) begin
            st_nxt.phase = PH_GATED;
          end else if (st_r.single_charge_bit) begin
            st_nxt.phase = PH_TERM;
          end else if (st_r.gate_on_finish) begin
            st_nxt.phase = PH_GATED;
          end
        end else if (!above_short) begin
          st_nxt.phase = PH_PRECOND;
        end
      end
      PH_GATED: begin
        // recharge comparator trips 120 mV under the charge voltage
        if (recharge_drop) begin
          st_nxt.phase = PH_FULL;
        end
      end
      PH_TERM: begin
        // left only when software clears the enable bit
        st_nxt.phase = PH_TERM;
      end
      default: begin
        st_nxt.phase = PH_PRECOND;
      end
    endcase
    if (!st_r.enable) begin
      st_nxt.phase = PH_PRECOND;
    end

    // sticky end-of-charge flag, set wins over clear
    if (wr_eoc_clr) begin
      st_nxt.eoc_flag = 1'b0;
    end
    if (eoc_hit) begin
      st_nxt.eoc_flag = 1'b1;
    end

    // static selects pass through a flop so every output leaves one
    st_nxt.otp_short = i_otp_short_threshold;
    st_nxt.otp_pre   = i_otp_precharge_current_sel;
    st_nxt.ready     = 1'b1;

    // registered loop controls, judged on the phase about to be entered
    st_nxt.charge_en  = 1'b0;
    st_nxt.sysreg_en  = 1'b0;
    st_nxt.short_cur  = 1'b0;
    st_nxt.pre_reduce = 1'b0;
    st_nxt.sys_ac     = 1'b0;
    st_nxt.supplement = 1'b0;
    if (st_r.enable) begin
      // gating and termination both stop the battery current
      st_nxt.charge_en = (st_nxt.phase != PH_GATED) && (st_nxt.phase != PH_TERM);
      // with power path the system rail stays regulated while gated
      st_nxt.sysreg_en = st_r.power_path || st_nxt.charge_en;
    end
    if (st_nxt.phase == PH_PRECOND) begin
      st_nxt.short_cur  = 1'b1;
      st_nxt.pre_reduce = st_r.power_path && sys_sag;
    end
    if (st_nxt.phase == PH_FULL) begin
      st_nxt.sys_ac = sys_sag;
    end
    if (st_r.power_path && st_nxt.charge_en) begin
      st_nxt.supplement = cur_zero;
    end
    st_nxt.tracking = st_r.power_path && above_batmin;
    st_nxt.ac_low   = !above_batmin;
    st_nxt.irq      = st_nxt.eoc_flag;

    // read data, captured in the address phase so it stands in the data phase
    st_nxt.rdata = 32'h0000_0000;
    if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
      case (i_haddr)
        `REG_CTRL_OFS: begin
          st_nxt.rdata = {23'h000000, st_r.eoc_flag, 1'b0, st_r.eoc_level,
                          st_r.power_path, st_r.gate_on_finish,
                          st_r.single_charge_bit, st_r.enable};
        end
        `REG_OTP_OFS: begin
          st_nxt.rdata = {22'h000000, i_otp_min_system_high_level,
                          i_otp_precharge_current_sel, i_otp_short_threshold};
        end
        `REG_BATMIN_OFS: begin
          st_nxt.rdata = {26'h0000000, st_r.battery_min_high_reg};
        end
        `REG_COMP_OFS: begin
          st_nxt.rdata = {30'h00000000, st_r.dropout_setting};
        end
        `REG_COLLAPSE_OFS: begin
          st_nxt.rdata = {29'h00000000, st_r.input_collapse_level};
        end
        `REG_LIMIT_OFS: begin
          st_nxt.rdata = {16'h0000, st_r.charge_current_sel,
                          st_r.charge_voltage_sel, st_r.input_current_sel};
        end
        `REG_STATUS_OFS: begin
          st_nxt.rdata = {23'h000000, st_r.sync2[8:3], st_r.phase};
        end
        default:           st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st_r                      <= '0;
      st_r.phase                <= PH_PRECOND;
      st_r.enable               <= 1'b1;
      st_r.gate_on_finish       <= 1'b1;
      st_r.power_path           <= 1'b1;
      st_r.dropout_setting      <= `COMP_RST;
      st_r.input_collapse_level <= `COLLAPSE_RST;
      st_r.input_current_sel    <= `INCUR_RST;
      st_r.charge_voltage_sel   <= `CHARGE_VOLT_RST;
      st_r.charge_current_sel   <= `ICHRG_RST;
      st_r.short_cur            <= 1'b1;
      st_r.ac_low               <= 1'b1;
      st_r.ready                <= 1'b1;
      // static levels are taken during reset so they are valid at release
      st_r.otp_short            <= i_otp_short_threshold;
      st_r.otp_pre              <= i_otp_precharge_current_sel;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_hrdata                      = st_r.rdata;
  assign o_hreadyout                   = st_r.ready;
  assign o_hresp                       = st_r.rdata[0] & 1'b0;
  assign o_phase                       = st_r.phase;
  assign o_charge_enable               = st_r.charge_en;
  assign o_system_reg_enable           = st_r.sysreg_en;
  assign o_short_current_sel           = st_r.short_cur;
  assign o_precond_reduce              = st_r.pre_reduce;
  assign o_precharge_current_sel       = st_r.otp_pre;
  assign o_short_threshold_sel         = st_r.otp_short;
  assign o_tracking_supply             = st_r.tracking;
  assign o_battery_min_high_level      = st_r.battery_min_high_reg;
  assign o_dropout_half_sel            = st_r.dropout_setting;
  assign o_sys_anticollapse_active     = st_r.sys_ac;
  assign o_anticollapse_low_fixed      = st_r.ac_low;
  assign o_end_of_charge_current_level = st_r.eoc_level;
  assign o_input_collapse_level        = st_r.input_collapse_level;
  assign o_input_current_sel           = st_r.input_current_sel;
  assign o_charge_voltage_sel          = st_r.charge_voltage_sel;
  assign o_charge_current_sel          = st_r.charge_current_sel;
  assign o_supplement_mode             = st_r.supplement;
  assign o_eoc_irq                     = st_r.irq;
endmodule // battery_charge_phase_control
`default_nettype wire

// ### core/charge_phase_consts.svh
`ifndef CHARGE_PHASE_CONSTS_SVH
`define CHARGE_PHASE_CONSTS_SVH
// register byte offsets
`define REG_CTRL_OFS      8'h00
`define REG_OTP_OFS       8'h04
`define REG_BATMIN_OFS    8'h08
`define REG_COMP_OFS      8'h0C
`define REG_COLLAPSE_OFS  8'h10
`define REG_LIMIT_OFS     8'h14
`define REG_STATUS_OFS    8'h18
// ctrl register field positions
`define CTRL_ENABLE_BIT   0
`define CTRL_SINGLE_BIT   1
`define CTRL_GATEFIN_BIT  2
`define CTRL_PPATH_BIT    3
`define CTRL_EOCLVL_LSB   4
`define CTRL_EOC_CLR_BIT  8
// reset values
`define CTRL_RST          32'h0000_000D
`define COMP_RST          2'h1
`define COLLAPSE_RST      3'h2
`define INCUR_RST         6'h08
`define CHARGE_VOLT_RST   6'h10
`define ICHRG_RST         4'h4
// clamp of the battery minimum high threshold, 3.7 V as a setting code
`define BATMIN_CLAMP      6'h25
// fixed currents and levels in mA and mV
`define SHORT_BAT_MA      12'h01E
`define SYS_AC_LOW_MV     13'h0D48
`define RECHARGE_DROP_MV  13'h0078
`endif

// ### core/charge_phase_pkg.sv
package charge_phase_pkg;
  typedef enum logic [2:0] {
    PH_PRECOND  = 3'b000,
    PH_PRECHG   = 3'b001,
    PH_FULL     = 3'b011,
    PH_GATED    = 3'b010,
    PH_TERM     = 3'b110
  } phase_t;
endpackage

// ### tb/battery_charge_phase_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "charge_phase_consts.svh"
module battery_charge_phase_control_test;
  import charge_phase_pkg::*;
  logic        clk, rst_b, hsel, hwrite, rd_dp, eoc_hit, drop, sag, zero;
  logic [7:0]  haddr;
  logic [1:0]  htrans, stage;
  logic [2:0]  hsize;
  logic [31:0] hwdata, r, q[$];
  logic [7:0]  ad[4] = '{`REG_COMP_OFS, `REG_COLLAPSE_OFS, `REG_BATMIN_OFS, `REG_LIMIT_OFS};
  logic [31:0] mk[4] = '{32'h3, 32'h7, 32'h1F, 32'hFFFF};
  wire logic [31:0] hrdata, ov[4];
  wire logic [2:0] phase, eoclvl, collapse;
  wire logic [5:0] batmin, incur, cvsel;
  wire logic [3:0] ichrg;
  wire logic [1:0] dropout;
  wire logic hready, chg_en, sys_en, short_sel, pc_red, track, lowfix, suppl, irq, sysac;
  wire logic c_sh, c_fu, c_bm, c_eoc, c_cv, c_rc, c_rg, c_sg, c_z;
  int fail_count, total_checks;
  assign ov[0] = {30'h0, dropout};
  assign ov[1] = {29'h0, collapse};
  assign ov[2] = {26'h0, batmin};
  assign ov[3] = {16'h0, ichrg, cvsel, incur};
  battery_model u_bat (.i_stage(stage), .i_eoc_hit(eoc_hit), .i_drop(drop), .i_sag(sag), .i_zero(zero),
    .o_above_short(c_sh), .o_above_full(c_fu), .o_above_batmin(c_bm), .o_eoc(c_eoc), .o_cv(c_cv),
    .o_recharge(c_rc), .o_regulated(c_rg), .o_sag(c_sg), .o_zero(c_z));
  battery_charge_phase_control dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(), .i_otp_short_threshold(2'h2),
    .i_otp_precharge_current_sel(2'h1), .i_otp_min_system_high_level(6'h3F), .i_cmp_above_short(c_sh),
    .i_cmp_above_full(c_fu), .i_cmp_above_batmin(c_bm), .i_cmp_eoc_current(c_eoc), .i_cmp_cv_regime(c_cv),
    .i_cmp_recharge_drop(c_rc), .i_cmp_source_regulated(c_rg), .i_cmp_sys_sag(c_sg),
    .i_cmp_charge_current_zero(c_z), .o_phase(phase), .o_charge_enable(chg_en), .o_system_reg_enable(sys_en),
    .o_short_current_sel(short_sel), .o_precond_reduce(pc_red), .o_precharge_current_sel(),
    .o_short_threshold_sel(), .o_tracking_supply(track), .o_battery_min_high_level(batmin),
    .o_dropout_half_sel(dropout), .o_sys_anticollapse_active(sysac), .o_anticollapse_low_fixed(lowfix),
    .o_end_of_charge_current_level(eoclvl), .o_input_collapse_level(collapse), .o_input_current_sel(incur),
    .o_charge_voltage_sel(cvsel), .o_charge_current_sel(ichrg), .o_supplement_mode(suppl), .o_eoc_irq(irq));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // read data phase results are matched against the oldest note
  always @(posedge clk) begin
    if (rd_dp) chk(hrdata, q.pop_front());
  end
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !wr;
    wait_rdy();
    rd_dp <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic wp(input phase_t p);
    int n;
    n = 0;
    while (phase !== p && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk({29'h0, phase}, {29'h0, p});
  endtask
  initial begin
    {hsel, hwrite, rd_dp, eoc_hit, drop, sag, zero} = 7'h0;
    haddr = 8'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stage = 2'h0;
    rst_b = 1'b0;
    r = 32'h15C0EA52;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`REG_CTRL_OFS, `CTRL_RST);
    rd(`REG_COMP_OFS, {30'h0, `COMP_RST});
    rd(`REG_COLLAPSE_OFS, {29'h0, `COLLAPSE_RST});
    rd(`REG_LIMIT_OFS, {16'h0, `ICHRG_RST, `CHARGE_VOLT_RST, `INCUR_RST});
    rd(`REG_BATMIN_OFS, {26'h0, `BATMIN_CLAMP});
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      xfer(1'b1, ad[i], r & mk[i]);
      rd(ad[i], r & mk[i]);
      chk(ov[i], r & mk[i]);
    end
    xfer(1'b1, 8'h1C, r);
    rd(8'h1C, 32'h0);
    xfer(1'b1, `REG_CTRL_OFS, 32'h5D);
    rd(`REG_CTRL_OFS, 32'h5D);
    chk({29'h0, eoclvl}, 32'h5);
    sag <= 1'b1;
    repeat (30) @(posedge clk);
    chk({27'h0, phase, short_sel, pc_red}, {27'h0, PH_PRECOND, 2'b11});
    sag <= 1'b0;
    stage <= 2'h1;
    wp(PH_PRECHG);
    stage <= 2'h2;
    wp(PH_FULL);
    zero <= 1'b1;
    sag <= 1'b1;
    repeat (6) @(posedge clk);
    chk({28'h0, track, lowfix, suppl, sysac}, 32'hB);
    zero <= 1'b0;
    sag <= 1'b0;
    eoc_hit <= 1'b1;
    repeat (10) @(posedge clk);
    chk({28'h0, phase, irq}, {28'h0, PH_FULL, 1'b0});
    stage <= 2'h3;
    wp(PH_GATED);
    chk({29'h0, chg_en, sys_en, irq}, 32'h3);
    eoc_hit <= 1'b0;
    drop <= 1'b1;
    wp(PH_FULL);
    drop <= 1'b0;
    xfer(1'b1, `REG_CTRL_OFS, 32'h10D);
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `REG_CTRL_OFS, 32'h3);
    eoc_hit <= 1'b1;
    wp(PH_TERM);
    eoc_hit <= 1'b0;
    drop <= 1'b1;
    repeat (10) @(posedge clk);
    chk({28'h0, phase, irq}, {28'h0, PH_TERM, 1'b1});
    drop <= 1'b0;
    xfer(1'b1, `REG_CTRL_OFS, 32'h0);
    wp(PH_PRECOND);
    xfer(1'b1, `REG_CTRL_OFS, 32'h5);
    wp(PH_FULL);
    eoc_hit <= 1'b1;
    wp(PH_GATED);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule // battery_charge_phase_control_test
bind battery_charge_phase_control charge_phase_checker u_chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_cmp_above_short(i_cmp_above_short), .i_cmp_above_batmin(i_cmp_above_batmin),
  .i_otp_short_threshold(i_otp_short_threshold), .i_otp_precharge_current_sel(i_otp_precharge_current_sel),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_phase(o_phase), .o_charge_enable(o_charge_enable),
  .o_short_current_sel(o_short_current_sel), .o_anticollapse_low_fixed(o_anticollapse_low_fixed),
  .o_eoc_irq(o_eoc_irq), .o_short_threshold_sel(o_short_threshold_sel),
  .o_precharge_current_sel(o_precharge_current_sel));
`default_nettype wire

// ### tb/battery_model.sv
`timescale 1ns/1ps
`default_nettype none
module battery_model (
  // scenario controls
  input  wire logic [1:0] i_stage,
  input  wire logic       i_eoc_hit,
  input  wire logic       i_drop,
  input  wire logic       i_sag,
  input  wire logic       i_zero,
  // comparator levels
  output logic            o_above_short,
  output logic            o_above_full,
  output logic            o_above_batmin,
  output logic            o_eoc,
  output logic            o_cv,
  output logic            o_recharge,
  output logic            o_regulated,
  output logic            o_sag,
  output logic            o_zero
);
  // stage: 0 shorted, 1 between thresholds, 2 above full, 3 constant voltage
  assign o_above_short  = (i_stage != 2'h0);
  assign o_above_full   = i_stage[1];
  assign o_above_batmin = i_stage[1];
  assign o_cv           = (i_stage == 2'h3);
  assign o_eoc          = i_eoc_hit;
  assign o_recharge     = i_drop;
  assign o_regulated    = 1'b1;
  assign o_sag          = i_sag;
  assign o_zero         = i_zero;
endmodule // battery_model
`default_nettype wire

// ### tb/charge_phase_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module charge_phase_checker
  import charge_phase_pkg::*;
(
  // clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_rst_b,
  // watched inputs
  input wire logic       i_cmp_above_short,
  input wire logic       i_cmp_above_batmin,
  input wire logic [1:0] i_otp_short_threshold,
  input wire logic [1:0] i_otp_precharge_current_sel,
  // watched outputs
  input wire logic       o_hreadyout,
  input wire logic       o_hresp,
  input wire logic [2:0] o_phase,
  input wire logic       o_charge_enable,
  input wire logic       o_short_current_sel,
  input wire logic       o_anticollapse_low_fixed,
  input wire logic       o_eoc_irq,
  input wire logic [1:0] o_short_threshold_sel,
  input wire logic [1:0] o_precharge_current_sel
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  chk_resp_okay: assert property (o_hresp == 1'b0)
    else $error("bus response not okay");
  chk_never_wait: assert property (o_hreadyout)
    else $error("slave inserted a wait");
  chk_short_current: assert property (o_phase == PH_PRECOND |-> o_short_current_sel)
    else $error("precondition without short current");
  chk_stay_short: assert property ((!i_cmp_above_short) [*6] |-> o_phase == PH_PRECOND)
    else $error("left precondition below short level");
  chk_stop_charge: assert property (o_phase inside {PH_GATED, PH_TERM} |-> !o_charge_enable)
    else $error("charging while gated or terminated");
  chk_irq_on_stop: assert property ($changed(o_phase) && o_phase inside {PH_GATED, PH_TERM}
    |-> ##[0:2] o_eoc_irq)
    else $error("no interrupt on end of charge");
  chk_low_fixed: assert property ((!i_cmp_above_batmin) [*6] |-> o_anticollapse_low_fixed)
    else $error("fixed anticollapse level not used");
  chk_otp_short: assert property (o_short_threshold_sel == i_otp_short_threshold)
    else $error("short threshold not from nonvolatile field");
  chk_otp_precharge: assert property (o_precharge_current_sel == i_otp_precharge_current_sel)
    else $error("precharge current not from nonvolatile field");
  chk_term_keep: assert property (o_phase == PH_TERM |=> o_phase inside {PH_TERM, PH_PRECOND})
    else $error("terminated charge restarted");
endmodule // charge_phase_checker
`default_nettype wire
